/* verilog/psr_pkg.sv */
// constants shared by the management status and identifier register logic
package psr_pkg;
  localparam logic [4:0] REG_CTRL    = 5'h00;
  localparam logic [4:0] REG_STAT    = 5'h01;
  localparam logic [4:0] REG_ID_HI   = 5'h02;
  localparam logic [4:0] REG_ID_LO   = 5'h03;
  localparam int CTL_DUPLEX_BIT      = 8;
  localparam int CTL_COLTEST_BIT     = 7;
  localparam int STS_CAP_LSB         = 11;
  localparam logic [4:0] STS_CAP_VAL = 5'h0F;
  localparam int STS_SKIP_BIT        = 6;
  localparam int STS_ANDONE_BIT      = 5;
  localparam int STS_RFAULT_BIT      = 4;
  localparam int STS_ANABLE_BIT      = 3;
  localparam int STS_LINK_BIT        = 2;
  localparam int STS_JABBER_BIT      = 1;
  localparam int STS_EXT_BIT         = 0;
  localparam logic [1:0] OP_WR       = 2'h1;
  localparam logic [1:0] OP_RD       = 2'h2;
  localparam logic [5:0] PRE_FULL    = 6'h20;
  localparam logic [5:0] PRE_SHORT   = 6'h02;
  localparam logic [4:0] HDR_LAST    = 5'h0C;
  localparam logic [4:0] TA_LAST     = 5'h01;
  localparam logic [4:0] DATA_LAST   = 5'h0F;
  localparam int REF_CLK_NS          = 25;
  localparam int BIT_TIME_NS         = 100;
  localparam int COL_ON_BT           = 512;
  localparam int COL_OFF_BT          = 4;
  localparam int COL_ON_CYC          = (COL_ON_BT * BIT_TIME_NS) / REF_CLK_NS;
  localparam int COL_OFF_CYC         = (COL_OFF_BT * BIT_TIME_NS) / REF_CLK_NS;
  typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} psr_frame_t;
endpackage : psr_pkg

/* verilog/psr_sync.sv */
// two-flop synchroniser for signals entering the reference clock domain
`timescale 1ns/100ps
`default_nettype none
module psr_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,    // reference clock
  input  wire logic         rst_n,  // synchronous reset, active low
  input  wire logic [W-1:0] d,      // asynchronous input
  output logic      [W-1:0] q       // synchronised output
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end
endmodule : psr_sync
`default_nettype wire

/* verilog/psr_regs.sv */
// serial management slave with control, status and identifier registers
`timescale 1ns/100ps
`default_nettype none
module psr_regs #(
  parameter logic [4:0]  PHY_ADDR = 5'h01,      // management address of this port
  parameter logic [23:0] ORG_ID   = 24'h3A5C69, // arbitrary value
  parameter logic [5:0]  MODEL_NO = 6'h15,      // arbitrary value
  parameter logic [3:0]  REV_NO   = 4'h1        // arbitrary value
) (
  input  wire logic REF_CLK,               // reference clock, 40 MHz
  input  wire logic RESET_N,               // synchronous reset, active low
  input  wire logic MDC,                   // management clock from controller
  input  wire logic MDIO_IN,               // management data, pin level
  output logic      MDIO_OUT,              // management data driven by port
  output logic      MDIO_OE_N,             // low while port drives data
  input  wire logic FULL_DUPLEX_STRAP_PIN, // full duplex strap pin
  input  wire logic AN_ENABLE,             // auto-negotiation enabled
  input  wire logic AN_FULL_DUPLEX,        // duplex resolved by auto-negotiation
  input  wire logic AN_COMPLETE,           // auto-negotiation done, pages valid
  input  wire logic REMOTE_FAULT,          // far-end fault from partner
  input  wire logic LINK_PASS,             // link state machine in link pass
  input  wire logic JABBER,                // jabber condition
  input  wire logic SPEED_10,              // operating at 10 Mb/s
  input  wire logic TX_EN,                 // transmit enable from controller
  output logic      COL,                   // collision output
  output logic      DUPLEX_FULL            // effective duplex setting
);
  logic [10:0] sync_q;
  logic mdc_s, mdio_s, strap_s, anen_s, anfd_s, andone_s;
  logic rf_s, link_s, jab_s, ten_s, txen_s;
  logic mdc_d_ff, mdc_rise;
  psr_pkg::psr_frame_t state_ff;
  logic [5:0]  ones_ff;
  logic [4:0]  cnt_ff;
  logic [11:0] hsh_ff;
  logic [15:0] sh_ff;
  logic [4:0]  addr_ff;
  logic        is_rd_ff;
  logic [12:0] hdr;
  logic        wr_stb_ff;
  logic [15:0] wr_data_ff;
  logic        rd_cap_ff;
  logic [15:0] rd_word_ff;
  logic        rd_clr;
  logic        ctl_dup_ff, ctl_col_ff, skip_ff;
  logic        rf_ff, link_fail_ff, jab_ff, link_d_ff;
  logic [15:0] rd_mux, stat_word, ctrl_word;

  psr_sync #(.W(11)) u_sync (
    .clk   (REF_CLK),
    .rst_n (RESET_N),
    .d     ({MDC, MDIO_IN, FULL_DUPLEX_STRAP_PIN, AN_ENABLE, AN_FULL_DUPLEX,
             AN_COMPLETE, REMOTE_FAULT, LINK_PASS, JABBER, SPEED_10, TX_EN}),
    .q     (sync_q)
  );
  assign {mdc_s, mdio_s, strap_s, anen_s, anfd_s, andone_s,
          rf_s, link_s, jab_s, ten_s, txen_s} = sync_q;

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) mdc_d_ff <= 1'b0;
    else          mdc_d_ff <= mdc_s;
  end
  assign mdc_rise = mdc_s & ~mdc_d_ff;
  assign hdr      = {hsh_ff, mdio_s};

  always_comb begin
    ctrl_word = '0;
    ctrl_word[psr_pkg::CTL_DUPLEX_BIT]  = ctl_dup_ff;
    ctrl_word[psr_pkg::CTL_COLTEST_BIT] = ctl_col_ff;
    stat_word = '0;
    stat_word[15:psr_pkg::STS_CAP_LSB]  = psr_pkg::STS_CAP_VAL;
    stat_word[psr_pkg::STS_SKIP_BIT]    = skip_ff;
    stat_word[psr_pkg::STS_ANDONE_BIT]  = andone_s;
    stat_word[psr_pkg::STS_RFAULT_BIT]  = rf_ff;
    stat_word[psr_pkg::STS_ANABLE_BIT]  = 1'b1;
    stat_word[psr_pkg::STS_LINK_BIT]    = link_s & ~link_fail_ff;
    stat_word[psr_pkg::STS_JABBER_BIT]  = jab_ff;
    stat_word[psr_pkg::STS_EXT_BIT]     = 1'b1;
    unique case (hdr[4:0])
      psr_pkg::REG_CTRL:  rd_mux = ctrl_word;
      psr_pkg::REG_STAT:  rd_mux = stat_word;
      psr_pkg::REG_ID_HI: rd_mux = ORG_ID[21:6];
      psr_pkg::REG_ID_LO: rd_mux = {ORG_ID[5:0], MODEL_NO, REV_NO};
      default:            rd_mux = '0;
    endcase
  end

  // read-to-clear fires in the capture cycle; the snapshot already holds the old bits
  assign rd_clr = mdc_rise && state_ff == psr_pkg::ST_HDR && cnt_ff == psr_pkg::HDR_LAST
                  && hdr[12] && hdr[9:5] == PHY_ADDR && hdr[11:10] == psr_pkg::OP_RD
                  && hdr[4:0] == psr_pkg::REG_STAT;

  // frame engine, advanced on each rising management clock edge
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      state_ff   <= psr_pkg::ST_PRE;
      ones_ff    <= '0;
      cnt_ff     <= '0;
      hsh_ff     <= '0;
      sh_ff      <= '0;
      addr_ff    <= '0;
      is_rd_ff   <= 1'b0;
      wr_stb_ff  <= 1'b0;
      wr_data_ff <= '0;
      rd_cap_ff  <= 1'b0;
      rd_word_ff <= '0;
      MDIO_OUT   <= 1'b1;
      MDIO_OE_N  <= 1'b1;
    end else begin
      wr_stb_ff <= 1'b0;
      rd_cap_ff <= 1'b0;
      if (mdc_rise) begin
        unique case (state_ff)
          psr_pkg::ST_PRE: begin
            MDIO_OE_N <= 1'b1;
            cnt_ff    <= '0;
            if (mdio_s) begin
              if (ones_ff != psr_pkg::PRE_FULL) ones_ff <= ones_ff + 6'h01;
            end else begin
              ones_ff <= '0;
              if (ones_ff >= (skip_ff ? psr_pkg::PRE_SHORT : psr_pkg::PRE_FULL))
                state_ff <= psr_pkg::ST_HDR;
            end
          end
          psr_pkg::ST_HDR: begin
            hsh_ff <= hdr[11:0];
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == psr_pkg::HDR_LAST) begin
              cnt_ff <= '0;
              // bad start, foreign address or bad opcode: wait for a new preamble
              if (hdr[12] && hdr[9:5] == PHY_ADDR &&
                  (hdr[11:10] == psr_pkg::OP_RD || hdr[11:10] == psr_pkg::OP_WR)) begin
                state_ff <= psr_pkg::ST_TA;
                addr_ff  <= hdr[4:0];
                is_rd_ff <= hdr[11:10] == psr_pkg::OP_RD;
                if (hdr[11:10] == psr_pkg::OP_RD) begin
                  sh_ff      <= rd_mux;
                  rd_word_ff <= rd_mux;
                  rd_cap_ff  <= 1'b1;
                end
              end else begin
                state_ff <= psr_pkg::ST_PRE;
              end
            end
          end
          psr_pkg::ST_TA: begin
            cnt_ff <= cnt_ff + 5'h01;
            if (cnt_ff == psr_pkg::TA_LAST) begin
              cnt_ff   <= '0;
              state_ff <= psr_pkg::ST_DATA;
              if (is_rd_ff) begin
                MDIO_OUT  <= 1'b0;
                MDIO_OE_N <= 1'b0;
              end
            end
          end
          psr_pkg::ST_DATA: begin
            cnt_ff <= cnt_ff + 5'h01;
            sh_ff  <= {sh_ff[14:0], mdio_s};
            if (is_rd_ff) MDIO_OUT <= sh_ff[15];
            if (cnt_ff == psr_pkg::DATA_LAST) begin
              state_ff <= psr_pkg::ST_PRE;
              ones_ff  <= '0;
              if (!is_rd_ff) begin
                wr_stb_ff  <= 1'b1;
                wr_data_ff <= {sh_ff[14:0], mdio_s};
              end
            end
          end
        endcase
      end
    end
  end

  // control bits
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      ctl_dup_ff <= 1'b0;
      ctl_col_ff <= 1'b0;
    end else if (wr_stb_ff && addr_ff == psr_pkg::REG_CTRL) begin
      ctl_dup_ff <= wr_data_ff[psr_pkg::CTL_DUPLEX_BIT];
      ctl_col_ff <= wr_data_ff[psr_pkg::CTL_COLTEST_BIT];
    end
  end

  // only the preamble skip bit of status takes a write
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N)
      skip_ff <= 1'b0;
    else if (wr_stb_ff && addr_ff == psr_pkg::REG_STAT)
      skip_ff <= wr_data_ff[psr_pkg::STS_SKIP_BIT];
  end

  // latched status indications; a set in the clearing cycle wins
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) begin
      rf_ff        <= 1'b0;
      link_fail_ff <= 1'b0;
      jab_ff       <= 1'b0;
      link_d_ff    <= 1'b0;
    end else begin
      link_d_ff    <= link_s;
      rf_ff        <= rf_s | (rf_ff & ~rd_clr);
      link_fail_ff <= (link_d_ff & ~link_s) | (link_fail_ff & ~rd_clr);
      jab_ff       <= (jab_s & ten_s) | (jab_ff & ~rd_clr);
    end
  end

  // collision test follows transmit enable after the sync delay, far inside both limits
  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) COL <= 1'b0;
    else          COL <= ctl_col_ff & txen_s;
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESET_N) DUPLEX_FULL <= 1'b0;
    else if (anen_s) DUPLEX_FULL <= anfd_s;
    else DUPLEX_FULL <= ctl_dup_ff | strap_s;
  end

  localparam int COL_WIN = 2;

  AST_DUPLEX: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !anen_s |=> DUPLEX_FULL == ($past(ctl_dup_ff) | $past(strap_s)))
    else $error("duplex not or of control bit and strap");
  AST_COL_ON: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (ctl_col_ff && txen_s) |-> ##[1:COL_WIN] COL)
    else $error("collision not raised after transmit enable");
  AST_COL_OFF: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    $fell(txen_s) |-> ##[1:COL_WIN] !COL)
    else $error("collision not lowered after transmit enable drop");
  AST_COLTEST_WR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (wr_stb_ff && addr_ff == psr_pkg::REG_CTRL) |=>
      ctl_col_ff == $past(wr_data_ff[psr_pkg::CTL_COLTEST_BIT]))
    else $error("collision test bit did not take write");
  AST_FIXED_BITS: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_STAT) |->
      rd_word_ff[15:psr_pkg::STS_CAP_LSB] == psr_pkg::STS_CAP_VAL &&
      rd_word_ff[psr_pkg::STS_ANABLE_BIT] && rd_word_ff[psr_pkg::STS_EXT_BIT])
    else $error("fixed status bits wrong");
  AST_SKIP_HOLD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !(wr_stb_ff && addr_ff == psr_pkg::REG_STAT) |=> $stable(skip_ff))
    else $error("preamble skip changed without status write");
  AST_ANDONE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_STAT) |->
      rd_word_ff[psr_pkg::STS_ANDONE_BIT] == $past(andone_s))
    else $error("completion bit does not follow auto-negotiation");
  AST_RF_HOLD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rf_ff && !rd_clr) |=> rf_ff)
    else $error("remote fault released without read");
  AST_LINK_LATCH: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (link_d_ff && !link_s) |=> link_fail_ff ##1 (link_fail_ff || $past(rd_clr)))
    else $error("link failure not latched");
  AST_JAB: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (jab_s && ten_s) |=> jab_ff)
    else $error("jabber not latched");
  AST_ID_LO: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_ID_LO) |->
      rd_word_ff == {ORG_ID[5:0], MODEL_NO, REV_NO})
    else $error("low identifier wrong");
  AST_RO_WRITE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (wr_stb_ff && addr_ff == psr_pkg::REG_STAT) |=>
      $stable(rf_ff) || $past(rf_s) || $past(rd_clr))
    else $error("write disturbed read-only status");

  // the hold checks above cannot see a latch that never clears, so the clears get their own
  AST_RF_CLR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_clr && !rf_s) |=> !rf_ff)
    else $error("remote fault kept after read with fault gone");
  AST_LINK_CLR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_clr && link_s) |=> !link_fail_ff)
    else $error("link failure kept after read with link up");
  AST_LINK_BIT: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_STAT) |->
      rd_word_ff[psr_pkg::STS_LINK_BIT] == $past(link_s && !link_fail_ff))
    else $error("link status bit wrong in snapshot");
  AST_JAB_SPEED: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    $rose(jab_ff) |-> $past(jab_s && ten_s))
    else $error("jabber latched outside 10 Mb/s");
  AST_JAB_CLR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_clr && !(jab_s && ten_s)) |=> !jab_ff)
    else $error("jabber kept after read");
  AST_RD_CLR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    rd_clr |=> (rd_cap_ff && addr_ff == psr_pkg::REG_STAT))
    else $error("status clear without snapshot");
  AST_SKIP_WR: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (wr_stb_ff && addr_ff == psr_pkg::REG_STAT) |=>
      skip_ff == $past(wr_data_ff[psr_pkg::STS_SKIP_BIT]))
    else $error("preamble skip did not take write");
  AST_CTRL_RD: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_CTRL) |->
      rd_word_ff[psr_pkg::CTL_COLTEST_BIT] == $past(ctl_col_ff))
    else $error("collision test bit read wrong");
  AST_COL_IDLE: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    !ctl_col_ff |=> !COL)
    else $error("collision raised outside test mode");
  AST_DUPLEX_AN: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    anen_s |=> DUPLEX_FULL == $past(anfd_s))
    else $error("duplex not resolved value with auto-negotiation on");
  AST_ID_HI: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (rd_cap_ff && addr_ff == psr_pkg::REG_ID_HI) |->
      rd_word_ff == ORG_ID[21:6])
    else $error("high identifier wrong");
endmodule : psr_regs
`default_nettype wire

/* tb/psr_mgmt_ctrl.sv */
// management controller model driving frames on the management clock and data pins
`timescale 1ns/100ps
`default_nettype none
module psr_mgmt_ctrl #(
  parameter logic [4:0] PHY_ADDR = 5'h01  // port address to call
) (
  input  wire logic clk,     // bench reference clock
  input  wire logic line,    // resolved data line level
  output logic      mdc,     // management clock, still between frames
  output logic      drv_en,  // high while the controller drives the line
  output logic      drv_d    // data driven by the controller
);
  initial begin
    mdc    = 1'b0;
    drv_en = 1'b0;
    drv_d  = 1'b1;
  end
  // one trailing idle slot so that read data bit 0 is caught on its closing rise
  task automatic xfer(input logic [1:0] op, input logic [4:0] ra, input logic [15:0] wd,
                      input int pre, output logic [15:0] rd);
    logic [31:0] frm;
    int          k;
    frm = {2'b01, op, PHY_ADDR, ra, 2'b10, wd};
    rd  = 16'h0;
    for (int i = 0; i <= pre + 32; i++) begin
      k = i - pre;
      @(posedge clk);
      drv_en <= !(k >= 32 || (op == psr_pkg::OP_RD && k >= 14));
      drv_d  <= (k < 0 || k >= 32) ? 1'b1 : frm[31-k];
      mdc    <= 1'b0;
      repeat (4) @(posedge clk);
      if (k >= 17 && k <= 32) rd[32-k] = line;
      mdc <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    mdc <= 1'b0;
  endtask : xfer
endmodule : psr_mgmt_ctrl
`default_nettype wire

/* tb/psr_regs_test.sv */
// self-checking bench for the management status and identifier registers
`timescale 1ns/100ps
`default_nettype none
`define PSR_CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e); end end
module psr_regs_test;
  localparam logic [23:0] ORG   = 24'hC3A5E1; // arbitrary value
  localparam logic [5:0]  MODEL = 6'h2B;      // arbitrary value
  localparam logic [3:0]  REV   = 4'h6;       // arbitrary value
  // steps {read twice, speed 10, fault, link, jabber}
  localparam logic [39:0] STEPS = {5'h1E, 5'h1A, 5'h08, 5'h1A, 5'h0B, 5'h1A, 5'h03, 5'h12};
  logic        ref_clk, reset_n, mdc, mdio_out, mdio_oe_n, drv_en, drv_d, line;
  logic        strap, an_en, an_fd, an_done, rfault, link, jab, sp10, tx_en, col, dup;
  logic        m_skip, m_rf, m_fail, m_jab;
  logic [31:0] seed;
  logic [15:0] rd;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          n;
  // released line floats high through its pull-up
  assign line = !mdio_oe_n ? mdio_out : (drv_en ? drv_d : 1'b1);
  psr_regs #(.PHY_ADDR(5'h01), .ORG_ID(ORG), .MODEL_NO(MODEL), .REV_NO(REV)) u_psr_regs (
    .REF_CLK(ref_clk), .RESET_N(reset_n), .MDC(mdc), .MDIO_IN(line), .MDIO_OUT(mdio_out),
    .MDIO_OE_N(mdio_oe_n), .FULL_DUPLEX_STRAP_PIN(strap), .AN_ENABLE(an_en),
    .AN_FULL_DUPLEX(an_fd), .AN_COMPLETE(an_done), .REMOTE_FAULT(rfault), .LINK_PASS(link),
    .JABBER(jab), .SPEED_10(sp10), .TX_EN(tx_en), .COL(col), .DUPLEX_FULL(dup));
  psr_mgmt_ctrl #(.PHY_ADDR(5'h01)) u_mgmt (.clk(ref_clk), .line(line), .mdc(mdc),
    .drv_en(drv_en), .drv_d(drv_d));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [15:0] exp_stat();
    return {1'b0, 4'hF, 4'h0, m_skip, an_done, m_rf, 1'b1, link & !m_fail, m_jab, 1'b1}
           & 16'hF87F;
  endfunction : exp_stat
  task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
    u_mgmt.xfer(psr_pkg::OP_WR, ra, wd, 32, rd);
  endtask : wr
  task automatic rdr(input logic [4:0] ra, input int pre);
    u_mgmt.xfer(psr_pkg::OP_RD, ra, 16'h0, pre, rd);
  endtask : rdr
  task automatic chk_stat(input int pre);
    seed = xs(seed);
    @(posedge ref_clk);
    an_done <= seed[7];
    repeat (6) @(posedge ref_clk);
    rdr(psr_pkg::REG_STAT, pre);
    `PSR_CHK(rd & 16'hF87F, exp_stat(), "status")
    m_rf   = rfault;
    m_fail = 1'b0;
    m_jab  = jab & sp10;
  endtask : chk_stat
  task automatic ev(input logic [4:0] st);
    @(posedge ref_clk);
    {sp10, rfault, link, jab} <= st[3:0];
    m_rf   = m_rf | st[2];
    m_fail = m_fail | (link & !st[1]);
    m_jab  = m_jab | (st[0] & st[3]);
    repeat (8) @(posedge ref_clk);
  endtask : ev
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    #2_000_000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    {reset_n, strap, an_en, an_fd, an_done, rfault, link, jab, sp10, tx_en} = 10'h08A;
    {m_skip, m_rf, m_fail, m_jab} = 4'h0;
    seed = 32'h0001227B;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk_stat(32);
    for (int a = 2; a <= 3; a++) begin
      seed = xs(seed);
      wr(a[4:0], seed[15:0]);
      rdr(a[4:0], 32);
      `PSR_CHK(rd, (a == 2 ? ORG[21:6] : {ORG[5:0], MODEL, REV}), "ident")
    end
    $display("identifier test done");
    rdr(psr_pkg::REG_STAT, 2);
    `PSR_CHK(rd, 16'hFFFF, "short preamble")
    seed = xs(seed);
    wr(psr_pkg::REG_STAT, {seed[15:11], 4'h0, 1'b1, seed[5:0]});
    m_skip = 1'b1;
    chk_stat(2);
    $display("preamble test done");
    for (int s = 0; s < 8; s++) begin
      ev(STEPS[5*(7-s) +: 5]);
      if (STEPS[5*(7-s)+4]) begin
        chk_stat(2);
        chk_stat(2);
      end
    end
    $display("latched status test done");
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      wr(psr_pkg::REG_CTRL, {7'h0, i[0], 8'h0});
      @(posedge ref_clk);
      {an_en, strap} <= i[2:1];
      an_fd <= seed[1];
      repeat (8) @(posedge ref_clk);
      `PSR_CHK(dup, an_en ? an_fd : (i[0] | strap), "duplex")
    end
    $display("duplex test done");
    for (int c = 1; c >= 0; c--) begin
      // loopback belongs to another block, so the mode is entered directly here
      wr(psr_pkg::REG_CTRL, {8'h0, c[0], 7'h0});
      rdr(psr_pkg::REG_CTRL, 32);
      `PSR_CHK(rd[8:7], ({1'b0, c[0]}), "control")
      @(posedge ref_clk);
      tx_en <= 1'b1;
      n = 0;
      while (col !== c[0] && n < psr_pkg::COL_ON_CYC + 8) begin
        @(posedge ref_clk);
        n++;
      end
      `PSR_CHK(n <= psr_pkg::COL_ON_CYC, 1'b1, "collision rise")
      repeat (20) @(posedge ref_clk);
      `PSR_CHK(col, c[0], "collision level")
      tx_en <= 1'b0;
      n = 0;
      while (col !== 1'b0 && n < 100) begin
        @(posedge ref_clk);
        n++;
      end
      `PSR_CHK(n <= psr_pkg::COL_OFF_CYC, 1'b1, "collision fall")
    end
    $display("collision test done");
    wr(psr_pkg::REG_CTRL, 16'h0080);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    {m_skip, m_rf, m_fail, m_jab} = 4'h0;
    rdr(psr_pkg::REG_CTRL, 32);
    `PSR_CHK(rd[8:7], 2'h0, "control after reset")
    chk_stat(32);
    $display("second reset test done");
    report_and_stop();
  end
endmodule : psr_regs_test
`default_nettype wire
